// File: rtl/servo_brake_sequencer.v
// holding brake and excitation sequencing, input function map and error overflow alarm
// assumes one 20 MHz clock, synchronous inputs and a single-cycle register port master
// Function
// RL1: delay settings apply only with brake output assigned
// RL2: positive wait: brake output first, then excitation
// RL3: negative wait: excitation first, then brake output
// RL4: standard sequence: brake output changes at disable
// RL5: at disable, engage once speed below setting
// RL6: at disable, engage once delay setting exceeded
// RL7: whichever disable condition comes first wins
// RL8: one hex digit per terminal, effective after restart; the code applies a written map on a CTRL write with the reload bit instead
// RL9: low map terminals one-four, high five-eight
// RL10: fixed terminal priority, last terminal ranks highest
// RL11: error above overflow limit raises alarm output
// RL12: re-enable before engage abandons disable sequence
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "servo_brake_regs.vh"
module servo_brake_sequencer #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	input  wire                clk,
	input  wire                rstn,
	input  wire [`ADDR_W-1:0]  reg_addr,
	input  wire [`DATA_W-1:0]  reg_wdata,
	input  wire                reg_wr,
	input  wire                reg_rd,
	output reg  [`DATA_W-1:0]  reg_rdata_r,
	input  wire                servo_enable,
	input  wire [15:0]         motor_speed,
	input  wire [31:0]         position_error,
	input  wire [7:0]          terminal_in,
	output wire [15:0]         input_function,
	output reg                 holding_brake_output,
	output reg                 excitation_on,
	output reg                 alarm_output,
	output wire                irq
);
	localparam [3:0] ST_IDLE     = 4'b0001;
	localparam [3:0] ST_ON_WAIT  = 4'b0010;
	localparam [3:0] ST_RUN      = 4'b0100;
	localparam [3:0] ST_OFF_WAIT = 4'b1000;

	reg  [15:0] ctrl_r;
	reg  [15:0] enable_wait_delay_r;
	reg  [15:0] basic_wait_sequence_r;
	reg  [15:0] brake_engage_speed_r;
	reg  [15:0] brake_engage_delay_r;
	reg  [15:0] input_function_map_low_r;
	reg  [15:0] input_function_map_high_r;
	reg  [15:0] position_error_overflow_limit_r;
	reg  [15:0] active_map_low_r;
	reg  [15:0] active_map_high_r;
	reg  [`IRQ_W-1:0] irq_status_r;
	reg  [`IRQ_W-1:0] irq_mask_r;
	reg  [3:0]  state_r;
	reg  [3:0]  state_nxt;
	reg         brake_nxt;
	reg         excite_nxt;
	reg         timer_clear;
	reg         abort_evt;
	wire [15:0] elapsed_ms;
	wire        brake_assigned;
	wire        wait_negative;
	wire [15:0] wait_mag;
	wire [15:0] speed_mag;
	wire [31:0] error_mag;
	wire        speed_low;
	wire        delay_over;
	wire        on_wait_done;
	wire        timer_run;
	wire        alarm_hit;
	wire        wr_ctrl;
	wire        wr_status;
	wire        engaged_evt;
	wire        released_evt;
	wire        alarm_evt;
	wire [`IRQ_W-1:0] irq_set;

	assign brake_assigned = ctrl_r[`CTRL_BRAKE_ASSIGNED];
	assign wait_negative  = enable_wait_delay_r[15];
	assign wait_mag       = wait_negative ? (~enable_wait_delay_r + 16'h0001) : enable_wait_delay_r;
	assign speed_mag      = motor_speed[15] ? (~motor_speed + 16'h0001) : motor_speed;
	assign error_mag      = position_error[31] ? (~position_error + 32'h0000_0001) : position_error;

	assign speed_low    = speed_mag < brake_engage_speed_r; // RL5
	assign delay_over   = elapsed_ms > brake_engage_delay_r; // RL6
	assign on_wait_done = elapsed_ms >= wait_mag;
	assign timer_run    = (state_r == ST_ON_WAIT) || (state_r == ST_OFF_WAIT);
	assign alarm_hit    = error_mag > {16'h0000, position_error_overflow_limit_r}; // RL11

	assign wr_ctrl   = reg_wr && (reg_addr == `REG_CTRL);
	assign wr_status = reg_wr && (reg_addr == `REG_IRQ_STATUS);

	brake_delay_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk          (clk),
		.rstn         (rstn),
		.clear        (timer_clear),
		.run          (timer_run),
		.elapsed_ms_r (elapsed_ms)
	);

	input_function_map u_map (
		.clk            (clk),
		.rstn           (rstn),
		.terminal_in    (terminal_in),
		.map_low        (active_map_low_r),
		.map_high       (active_map_high_r),
		.function_out_r (input_function)
	);

	// holding_brake_output high lifts the brake, low lets it hold the shaft
	always @* begin
		state_nxt   = state_r;
		brake_nxt   = holding_brake_output;
		excite_nxt  = excitation_on;
		timer_clear = 1'b0;
		abort_evt   = 1'b0;
		case (state_r)
			ST_IDLE: begin
				brake_nxt  = 1'b0;
				excite_nxt = 1'b0;
				if (servo_enable) begin
					timer_clear = 1'b1;
					if (!brake_assigned || wait_mag == 16'h0000) begin // RL1
						brake_nxt  = brake_assigned;
						excite_nxt = 1'b1;
						state_nxt  = ST_RUN;
					end else if (!wait_negative) begin
						brake_nxt = 1'b1; // RL2
						state_nxt = ST_ON_WAIT;
					end else begin
						excite_nxt = 1'b1; // RL3
						state_nxt  = ST_ON_WAIT;
					end
				end
			end
			ST_ON_WAIT: begin
				if (!servo_enable) begin
					brake_nxt  = 1'b0;
					excite_nxt = 1'b0;
					abort_evt  = 1'b1;
					state_nxt  = ST_IDLE;
				end else if (!brake_assigned) begin
					// assignment withdrawn mid-wait: no brake sequencing left to do
					brake_nxt  = 1'b0; // RL1
					excite_nxt = 1'b1;
					state_nxt  = ST_RUN;
				end else if (on_wait_done) begin
					brake_nxt  = 1'b1; // RL3
					excite_nxt = 1'b1; // RL2
					state_nxt  = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!brake_assigned) begin
					brake_nxt = 1'b0; // RL1
				end
				if (!servo_enable) begin
					excite_nxt  = 1'b0;
					timer_clear = 1'b1;
					if (!brake_assigned || basic_wait_sequence_r == 16'h0000) begin
						brake_nxt = 1'b0; // RL4
						state_nxt = ST_IDLE;
					end else if (speed_low) begin
						brake_nxt = 1'b0; // RL5
						state_nxt = ST_IDLE;
					end else begin
						state_nxt = ST_OFF_WAIT;
					end
				end
			end
			ST_OFF_WAIT: begin
				if (servo_enable) begin
					// re-enable before engage: drop the countdown, keep the brake lifted
					timer_clear = 1'b1; // RL12
					excite_nxt  = 1'b1;
					abort_evt   = 1'b1;
					state_nxt   = ST_RUN;
				end else if (speed_low || delay_over || !brake_assigned) begin
					brake_nxt = 1'b0; // RL7
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				brake_nxt  = 1'b0;
				excite_nxt = 1'b0;
				state_nxt  = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			state_r              <= ST_IDLE;
			holding_brake_output <= 1'b0;
			excitation_on        <= 1'b0;
		end else begin
			state_r              <= state_nxt;
			holding_brake_output <= brake_nxt;
			excitation_on        <= excite_nxt;
		end
	end

	// alarm stays latched until software clears it and the error is back in range
	always @(posedge clk) begin
		if (!rstn) begin
			alarm_output <= 1'b0;
		end else if (alarm_hit) begin
			alarm_output <= 1'b1; // RL11
		end else if (wr_ctrl && reg_wdata[`CTRL_ALARM_CLEAR]) begin
			alarm_output <= 1'b0;
		end
	end

	// working maps change only on reset or an explicit reload, never on a plain write
	always @(posedge clk) begin
		if (!rstn) begin
			active_map_low_r  <= `MAP_LOW_RESET;
			active_map_high_r <= `MAP_HIGH_RESET;
		end else if (wr_ctrl && reg_wdata[`CTRL_MAP_RELOAD]) begin
			active_map_low_r  <= input_function_map_low_r; // RL8
			active_map_high_r <= input_function_map_high_r;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			ctrl_r                          <= `CTRL_RESET;
			enable_wait_delay_r             <= `ENABLE_WAIT_RESET;
			basic_wait_sequence_r           <= `BASIC_WAIT_RESET;
			brake_engage_speed_r            <= `ENGAGE_SPEED_RESET;
			brake_engage_delay_r            <= `ENGAGE_DELAY_RESET;
			input_function_map_low_r        <= `MAP_LOW_RESET;
			input_function_map_high_r       <= `MAP_HIGH_RESET;
			position_error_overflow_limit_r <= `ERR_LIMIT_RESET;
			irq_mask_r                      <= {`IRQ_W{1'b0}};
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_CTRL:         ctrl_r                          <= {15'h0000, reg_wdata[0]};
				`REG_ENABLE_WAIT:  enable_wait_delay_r             <= reg_wdata;
				`REG_BASIC_WAIT:   basic_wait_sequence_r           <= reg_wdata;
				`REG_ENGAGE_SPEED: brake_engage_speed_r            <= reg_wdata;
				`REG_ENGAGE_DELAY: brake_engage_delay_r            <= reg_wdata;
				`REG_MAP_LOW:      input_function_map_low_r        <= reg_wdata;
				`REG_MAP_HIGH:     input_function_map_high_r       <= reg_wdata;
				`REG_ERR_LIMIT:    position_error_overflow_limit_r <= reg_wdata;
				`REG_IRQ_MASK:     irq_mask_r                      <= reg_wdata[`IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	assign engaged_evt  = holding_brake_output && !brake_nxt;
	assign released_evt = !holding_brake_output && brake_nxt;
	assign alarm_evt    = alarm_hit && !alarm_output;
	assign irq_set      = {abort_evt, alarm_evt, released_evt, engaged_evt};

	// a new event in the clearing cycle survives the write-one-to-clear
	always @(posedge clk) begin
		if (!rstn) begin
			irq_status_r <= {`IRQ_W{1'b0}};
		end else if (wr_status) begin
			irq_status_r <= (irq_status_r & ~reg_wdata[`IRQ_W-1:0]) | irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// read data valid only in the cycle after the strobe, zero elsewhere
	always @(posedge clk) begin
		if (!rstn || !reg_rd) begin
			reg_rdata_r <= 16'h0000;
		end else begin
			case (reg_addr)
				`REG_CTRL:         reg_rdata_r <= ctrl_r;
				`REG_ENABLE_WAIT:  reg_rdata_r <= enable_wait_delay_r;
				`REG_BASIC_WAIT:   reg_rdata_r <= basic_wait_sequence_r;
				`REG_ENGAGE_SPEED: reg_rdata_r <= brake_engage_speed_r;
				`REG_ENGAGE_DELAY: reg_rdata_r <= brake_engage_delay_r;
				`REG_MAP_LOW:      reg_rdata_r <= input_function_map_low_r;
				`REG_MAP_HIGH:     reg_rdata_r <= input_function_map_high_r;
				`REG_ERR_LIMIT:    reg_rdata_r <= position_error_overflow_limit_r;
				`REG_IRQ_STATUS:   reg_rdata_r <= {12'h000, irq_status_r};
				`REG_IRQ_MASK:     reg_rdata_r <= {12'h000, irq_mask_r};
				`REG_STATE:        reg_rdata_r <= {5'h00, alarm_output, excitation_on,
				                                  holding_brake_output, 4'h0, state_r};
				default:           reg_rdata_r <= 16'h0000;
			endcase
		end
	end
endmodule // servo_brake_sequencer

// File: pkg/servo_brake_regs.vh
// register offsets, field positions, reset values and timing counts of the brake sequencer
// assumes a 16-bit register port addressed by byte offset, one register per aligned word
`ifndef SERVO_BRAKE_REGS_VH
`define SERVO_BRAKE_REGS_VH

`define ADDR_W              8
`define DATA_W              16

`define REG_CTRL            8'h00
`define REG_ENABLE_WAIT     8'h04
`define REG_BASIC_WAIT      8'h08
`define REG_ENGAGE_SPEED    8'h0C
`define REG_ENGAGE_DELAY    8'h10
`define REG_MAP_LOW         8'h14
`define REG_MAP_HIGH        8'h18
`define REG_ERR_LIMIT       8'h1C
`define REG_IRQ_STATUS      8'h20
`define REG_IRQ_MASK        8'h24
`define REG_STATE           8'h28

// control register fields
`define CTRL_BRAKE_ASSIGNED 0
`define CTRL_MAP_RELOAD     1
`define CTRL_ALARM_CLEAR    2

// interrupt status fields
`define IRQ_BRAKE_ENGAGED   0
`define IRQ_BRAKE_RELEASED  1
`define IRQ_ALARM           2
`define IRQ_ABORT           3
`define IRQ_W               4

`define CTRL_RESET          16'h0000
`define ENABLE_WAIT_RESET   16'h0000
`define BASIC_WAIT_RESET    16'h0000
`define ENGAGE_SPEED_RESET  16'h001E
`define ENGAGE_DELAY_RESET  16'h01F4
`define MAP_LOW_RESET       16'h3210
`define MAP_HIGH_RESET      16'h7654
`define ERR_LIMIT_RESET     16'h7FFF

// delays count in milliseconds of the 50 ns clock
`define CLK_PERIOD_NS       50
`define DELAY_UNIT_NS       1000000
`define TICK_CYCLES         (`DELAY_UNIT_NS / `CLK_PERIOD_NS)

`endif

// File: rtl/brake_delay_timer.v
// millisecond timer for the brake sequencer: divider pulse plus saturating count
// assumes clear and run come from the sequencer state in the same clock domain
`timescale 1ns/1ps
module brake_delay_timer #(
	parameter TICK_CYCLES = 20000
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        clear,
	input  wire        run,
	output reg  [15:0] elapsed_ms_r
);
	reg [15:0] div_r;
	wire       tick;

	assign tick = run && (div_r == TICK_CYCLES[15:0] - 16'h0001);

	always @(posedge clk) begin
		if (!rstn || clear || !run) begin
			div_r <= 16'h0000;
		end else if (tick) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// saturates so a huge setting never wraps back to a short wait
	always @(posedge clk) begin
		if (!rstn || clear) begin
			elapsed_ms_r <= 16'h0000;
		end else if (tick && elapsed_ms_r != 16'hFFFF) begin
			elapsed_ms_r <= elapsed_ms_r + 16'h0001;
		end
	end
endmodule // brake_delay_timer

// File: rtl/input_function_map.v
// maps eight input terminals onto sixteen input functions by one hex digit each
// assumes terminal levels are already synchronous and filtered
`timescale 1ns/1ps
module input_function_map (
	input  wire        clk,
	input  wire        rstn,
	input  wire [7:0]  terminal_in,
	input  wire [15:0] map_low,
	input  wire [15:0] map_high,
	output reg  [15:0] function_out_r
);
	wire [31:0] maps;

	// digit k of the joined word serves terminal k
	assign maps = {map_high, map_low}; // RL9

	genvar f;
	generate
		for (f = 0; f < 16; f = f + 1) begin : g_func
			localparam [3:0] FUNC_CODE = f;
			reg     level;
			integer i;
			// later terminal overrides earlier, so the last one ranks highest
			always @* begin
				level = 1'b0;
				for (i = 0; i < 8; i = i + 1) begin
					if (maps[i*4 +: 4] == FUNC_CODE) begin // RL8
						level = terminal_in[i]; // RL10
					end
				end
			end
			always @(posedge clk) begin
				if (!rstn) begin
					function_out_r[f] <= 1'b0;
				end else begin
					function_out_r[f] <= level;
				end
			end
		end
	endgenerate
endmodule // input_function_map

// File: verif/servo_brake_sequencer_asserts.sv
// port assertions for the brake sequencer, with shadows of the settings they depend on
// assumes bind into servo_brake_sequencer; register writes take effect on the strobe edge
`timescale 1ns/1ps
`include "servo_brake_regs.vh"
module servo_brake_checker #(
	parameter TICK_CYCLES = 4
) (
	input wire        clk,
	input wire        rstn,
	input wire [7:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata_r,
	input wire        servo_enable,
	input wire [15:0] motor_speed,
	input wire [31:0] position_error,
	input wire [7:0]  terminal_in,
	input wire [15:0] input_function,
	input wire        holding_brake_output,
	input wire        excitation_on,
	input wire        alarm_output,
	input wire        irq
);
	reg         assigned_r;
	reg         slow_r;
	reg  [15:0] wait_r;
	reg  [15:0] speed_r;
	reg  [15:0] delay_r;
	reg  [15:0] limit_r;
	reg  [15:0] off_cnt_r;
	wire [15:0] spd_mag = motor_speed[15] ? -motor_speed : motor_speed;
	wire [31:0] err_mag = position_error[31] ? -position_error : position_error;
	wire        wait_pos = !wait_r[15] && wait_r != 16'h0000;
	always @(posedge clk) begin
		if (!rstn) begin
			assigned_r <= 1'b0;
			slow_r     <= 1'b0;
			wait_r     <= `ENABLE_WAIT_RESET;
			speed_r    <= `ENGAGE_SPEED_RESET;
			delay_r    <= `ENGAGE_DELAY_RESET;
			limit_r    <= `ERR_LIMIT_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
			`REG_CTRL:         assigned_r <= reg_wdata[0];
			`REG_BASIC_WAIT:   slow_r <= |reg_wdata;
			`REG_ENABLE_WAIT:  wait_r <= reg_wdata;
			`REG_ENGAGE_SPEED: speed_r <= reg_wdata;
			`REG_ENGAGE_DELAY: delay_r <= reg_wdata;
			`REG_ERR_LIMIT:    limit_r <= reg_wdata;
			default: ;
			endcase
		end
	end
	// ms tick phase is unknown here, so the delay bound carries slack
	always @(posedge clk) begin
		if (!rstn || servo_enable)
			off_cnt_r <= 16'h0000;
		else if (off_cnt_r != 16'hFFFF)
			off_cnt_r <= off_cnt_r + 16'h0001;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	rd_slot_zero_a: assert property (!reg_rd |=> reg_rdata_r == 16'h0000)
		else $error("read data outside its slot");
	unassigned_brake_a: assert property (!assigned_r [*3] |-> !holding_brake_output)
		else $error("brake lifted while unassigned");
	pos_wait_a: assert property (assigned_r && wait_pos && $rose(servo_enable) && !holding_brake_output
		|-> ##[1:2] (holding_brake_output && !excitation_on)) else $error("positive wait order");
	neg_wait_a: assert property (assigned_r && wait_r[15] && $rose(servo_enable) && !holding_brake_output
		|-> ##[1:2] (excitation_on && !holding_brake_output)) else $error("negative wait order");
	std_brake_a: assert property (assigned_r && !slow_r && $fell(servo_enable)
		|-> ##[1:2] !holding_brake_output) else $error("standard brake late");
	speed_engage_a: assert property (assigned_r && slow_r && !servo_enable && spd_mag < speed_r
		|-> ##[1:2] !holding_brake_output) else $error("speed engage missed");
	delay_engage_a: assert property ({16'h0000, off_cnt_r} > ({16'h0000, delay_r} + 32'h2) * TICK_CYCLES + 32'h4
		|-> !holding_brake_output) else $error("delay engage missed");
	reenable_keep_a: assert property (assigned_r && slow_r && $rose(servo_enable) && holding_brake_output
		|-> ##[1:2] (holding_brake_output && excitation_on)) else $error("re-enable not resumed");
	alarm_raise_a: assert property (err_mag > {16'h0000, limit_r} |-> ##[1:2] alarm_output)
		else $error("overflow alarm missing");
	cover property ($fell(holding_brake_output) && slow_r);
	cover property ($rose(excitation_on) && holding_brake_output);
	cover property ($rose(alarm_output));
endmodule // servo_brake_checker

bind servo_brake_sequencer servo_brake_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .servo_enable(servo_enable), .motor_speed(motor_speed),
	.position_error(position_error), .terminal_in(terminal_in), .input_function(input_function),
	.holding_brake_output(holding_brake_output), .excitation_on(excitation_on),
	.alarm_output(alarm_output), .irq(irq)
);

// File: verif/motor_load_model.sv
// motor and load behind the drive: speed follows excitation, coasts, or is held by the brake
// assumes brake output high means brake lifted; coast_step zero gives a load that never slows
`timescale 1ns/1ps
module motor_load_model (
	input wire        clk,
	input wire        rstn,
	input wire        excitation_on,
	input wire        holding_brake_output,
	input wire [15:0] target_speed,
	input wire [15:0] coast_step,
	output reg [15:0] motor_speed_r
);
	wire [15:0] mag = motor_speed_r[15] ? -motor_speed_r : motor_speed_r;
	always @(posedge clk) begin
		if (!rstn)
			motor_speed_r <= 16'h0000;
		else if (excitation_on)
			motor_speed_r <= target_speed;
		else if (!holding_brake_output || mag <= coast_step)
			motor_speed_r <= 16'h0000;
		else if (motor_speed_r[15])
			motor_speed_r <= motor_speed_r + coast_step;
		else
			motor_speed_r <= motor_speed_r - coast_step;
	end
endmodule // motor_load_model

// File: verif/servo_brake_sequencer_tb.sv
// self-checking bench for the brake sequencer driving a motor load model
// assumes the register header on the include path and a 4-cycle ms tick
`timescale 1ns/1ps
`include "servo_brake_regs.vh"
module servo_brake_sequencer_tb;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [15:0] reg_wdata = 16'h0000;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         servo_enable = 1'b0;
	reg  [31:0] position_error = 32'h00000000;
	reg  [7:0]  terminal_in = 8'h00;
	reg  [15:0] target_speed = 16'h0100;
	reg  [15:0] coast_step = 16'h0000;
	wire [15:0] reg_rdata_r;
	wire [15:0] motor_speed;
	wire [15:0] input_function;
	wire        holding_brake_output;
	wire        excitation_on;
	wire        alarm_output;
	wire        irq;
	reg         rd_seen = 1'b0;
	reg  [15:0] exp_q[$];
	reg  [31:0] r;
	integer     miscompares = 0;
	integer     cmp_count = 0;
	integer     n;
	servo_brake_sequencer #(.TICK_CYCLES(4)) dut (
		.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .servo_enable(servo_enable), .motor_speed(motor_speed),
		.position_error(position_error), .terminal_in(terminal_in), .input_function(input_function),
		.holding_brake_output(holding_brake_output), .excitation_on(excitation_on),
		.alarm_output(alarm_output), .irq(irq));
	motor_load_model load (.clk(clk), .rstn(rstn), .excitation_on(excitation_on),
		.holding_brake_output(holding_brake_output), .target_speed(target_speed),
		.coast_step(coast_step), .motor_speed_r(motor_speed));
	initial begin
		forever #25 clk = ~clk;
	end
	task check(input [15:0] seen, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("compares %0d mismatches %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk);
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			cyc(1);
			reg_wr <= 1'b0;
			cyc(1);
		end
	endtask
	task rd(input [7:0] a, input [15:0] e);
		begin
			exp_q.push_back(e);
			reg_addr <= a;
			reg_rd <= 1'b1;
			cyc(1);
			reg_rd <= 1'b0;
			cyc(1);
		end
	endtask
	// e is {alarm, irq, brake, excitation}; looks once the edge has settled
	task probe(input [15:0] f, input [3:0] e);
		begin
			#1;
			check(input_function, f);
			check({12'h000, alarm_output, irq, holding_brake_output, excitation_on}, {12'h000, e});
			cyc(1);
		end
	endtask
	task wait_lvl(input sel, input v);
		begin
			n = 0;
			#1;
			while ((sel ? holding_brake_output : excitation_on) !== v && n < 1000) begin
				cyc(1);
				#1;
				n = n + 1;
			end
			cyc(1);
		end
	endtask
	always @(posedge clk) begin
		rd_seen <= reg_rd;
		if (rd_seen)
			check(reg_rdata_r, exp_q.pop_front());
	end
	initial begin
		cyc(20000);
		miscompares = miscompares + 1;
		final_report;
	end
	initial begin
		void'($urandom(43654));
		cyc(8);
		rstn <= 1'b1;
		cyc(1);
		rd(`REG_ENGAGE_SPEED, `ENGAGE_SPEED_RESET);
		rd(`REG_ENGAGE_DELAY, `ENGAGE_DELAY_RESET);
		rd(`REG_MAP_LOW, `MAP_LOW_RESET);
		rd(`REG_MAP_HIGH, `MAP_HIGH_RESET);
		rd(`REG_STATE, 16'h0001);
		rd(8'h3C, 16'h0000);
		wr(`REG_ENABLE_WAIT, 16'h0002);
		servo_enable <= 1'b1;
		cyc(3);
		probe(16'h0000, 4'h1);
		servo_enable <= 1'b0;
		cyc(3);
		probe(16'h0000, 4'h0);
		wr(`REG_CTRL, 16'h0001);
		servo_enable <= 1'b1;
		cyc(2);
		probe(16'h0000, 4'h2);
		wait_lvl(1'b0, 1'b1);
		check(n >= 2 && n <= 13, 16'h0001);
		rd(`REG_STATE, 16'h0304);
		servo_enable <= 1'b0;
		cyc(2);
		probe(16'h0000, 4'h0);
		wr(`REG_ENABLE_WAIT, 16'hFFFE);
		servo_enable <= 1'b1;
		cyc(2);
		probe(16'h0000, 4'h1);
		wait_lvl(1'b1, 1'b1);
		check(n >= 2 && n <= 13, 16'h0001);
		wr(`REG_BASIC_WAIT, 16'h0001);
		wr(`REG_ENGAGE_SPEED, 16'h0010);
		wr(`REG_ENGAGE_DELAY, 16'h0003);
		target_speed <= 16'hFF00;
		cyc(2);
		servo_enable <= 1'b0;
		cyc(2);
		probe(16'h0000, 4'h2);
		wait_lvl(1'b1, 1'b0);
		check(n >= 6 && n <= 21, 16'h0001);
		wr(`REG_ENABLE_WAIT, 16'h0000);
		wr(`REG_ENGAGE_DELAY, 16'h0064);
		coast_step <= 16'h0020;
		servo_enable <= 1'b1;
		cyc(3);
		servo_enable <= 1'b0;
		wait_lvl(1'b1, 1'b0);
		check(n >= 8 && n <= 16, 16'h0001);
		coast_step <= 16'h0000;
		servo_enable <= 1'b1;
		cyc(3);
		servo_enable <= 1'b0;
		cyc(3);
		probe(16'h0000, 4'h2);
		servo_enable <= 1'b1;
		cyc(3);
		probe(16'h0000, 4'h3);
		rd(`REG_IRQ_STATUS, 16'h000B);
		wr(`REG_IRQ_STATUS, 16'h000F);
		wr(`REG_IRQ_MASK, 16'h0004);
		wr(`REG_ERR_LIMIT, 16'h0100);
		position_error <= 32'hFFFFFEFF;
		cyc(3);
		probe(16'h0000, 4'hF);
		position_error <= 32'h00000100;
		wr(`REG_CTRL, 16'h0005);
		probe(16'h0000, 4'h7);
		wr(`REG_IRQ_STATUS, 16'h0004);
		probe(16'h0000, 4'h3);
		r = $urandom;
		terminal_in <= r[7:0];
		cyc(2);
		probe({8'h00, r[7:0]}, 4'h3);
		wr(`REG_MAP_LOW, 16'h0000);
		wr(`REG_MAP_HIGH, 16'hA000);
		terminal_in <= r[15:8];
		cyc(2);
		probe({8'h00, r[15:8]}, 4'h3);
		wr(`REG_CTRL, 16'h0003);
		cyc(2);
		probe({5'h00, r[15], 9'h000, r[14]}, 4'h3);
		terminal_in <= 8'h3F;
		cyc(2);
		probe(16'h0000, 4'h3);
		rd(`REG_MAP_HIGH, 16'hA000);
		wr(`REG_BASIC_WAIT, 16'h0000);
		servo_enable <= 1'b0;
		wr(`REG_ENABLE_WAIT, 16'h0005);
		servo_enable <= 1'b1;
		cyc(2);
		probe(16'h0000, 4'h2);
		servo_enable <= 1'b0;
		cyc(2);
		probe(16'h0000, 4'h0);
		rd(`REG_IRQ_STATUS, 16'h000B);
		cyc(2);
		final_report;
	end
endmodule // servo_brake_sequencer_tb
